// *** rtl/tpa_ctrl.sv ***
// Purpose: Control word capture, acquisition timing, driver and reference routing
// Assumes: Serial side runs on serial_clock_in; routing outputs on mclk
// Notes:   Serial logic samples serial_data_in on the rising serial clock edge
`timescale 1ns/1ps

// Overview of operation
// - Tracking starts at fifth falling edge after start
// - Acquisition lasts three serial clock cycles
// - Both power bits one keep drivers on
// - Fifteen-clock mode keeps drivers on continuously
// - Upper power bit enables internal reference
// - Reference switch closed only while reference enabled
// - Select one gives single-ended ground-to-reference conversion
// - Y measurement routes X-high, enables Y drivers
// - Single-ended drivers may switch off after acquisition
// - Single-ended reference source follows power bits
// - Select zero ties reference to driven plates, Y for Y measurement
// - Differential keeps drivers on through conversion
// - Two temperature conversions, base then multiple current
// - Serial input ignored until start bit one
// - Select bit one single-ended, zero differential
// - Resolution zero gives 12 bits, one 8
module tpa_ctrl (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic serial_clock_in,
   input  wire logic serial_data_in,
   input  wire logic fifteen_clock_mode,
   output logic      track_active,
   output logic      conv_active,
   output logic      x_plus_drv,
   output logic      x_minus_drv,
   output logic      y_plus_drv,
   output logic      y_minus_drv,
   output logic      ref_enable,
   output logic      reference_output_switch,
   output logic      ref_plus_is_vref,
   output logic      ref_plus_is_yp,
   output logic      ref_plus_is_xp,
   output logic      ref_minus_is_gnd,
   output logic      ref_minus_is_ym,
   output logic      ref_minus_is_xm,
   output logic      adc_in_xp,
   output logic      adc_in_yp,
   output logic      adc_in_ym,
   output logic      adc_in_aux,
   output logic      adc_in_vbat,
   output logic      adc_in_temp,
   output logic      temp_bias_multiple,
   output logic      res_8bit,
   output logic      reference_select
);
   // ----------------------------------------------------------------
   // Serial domain: word capture and acquisition timing
   // ----------------------------------------------------------------
   tpa_pkg::tpa_state_e st_reg;
   tpa_pkg::tpa_state_e st_next;
   logic [6:0]          shift_reg;
   logic [4:0]          cnt_reg;
   logic [6:0]          word_reg;
   logic                track_s_reg;
   logic                conv_s_reg;
   logic                load_pulse_s;
   logic                fall_count_hit;
   logic                acq_done;
   logic                conv_done;
   logic [4:0]          conv_len;

   assign conv_len = word_reg[tpa_pkg::POS_RES] ? 5'(tpa_pkg::CONV_BITS_8)
                                                : 5'(tpa_pkg::CONV_BITS_12);
   // Fifth falling edge after start: the rising edge that took bit index 4
   assign fall_count_hit = (st_reg == tpa_pkg::tpa_word_e) &&
                           (cnt_reg == 5'(tpa_pkg::TRACK_FALL - 1));
   // Tracking opens at the fifth edge and must close three edges later; the word
   // takes two more edges, so the acquire state covers only what is left over
   assign acq_done  = (st_reg == tpa_pkg::tpa_acq_e) &&
                      (cnt_reg == 5'(tpa_pkg::TRACK_FALL + tpa_pkg::ACQ_CYCLES -
                                     tpa_pkg::CTRL_BITS - 1));
   assign conv_done = (st_reg == tpa_pkg::tpa_conv_e) && (cnt_reg == conv_len - 5'h01);

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         tpa_pkg::tpa_idle_e: if (serial_data_in) st_next = tpa_pkg::tpa_word_e;
         tpa_pkg::tpa_word_e: if (cnt_reg == 5'(tpa_pkg::CTRL_BITS - 1))
                                 st_next = tpa_pkg::tpa_acq_e;
         tpa_pkg::tpa_acq_e:  if (acq_done) st_next = tpa_pkg::tpa_conv_e;
         tpa_pkg::tpa_conv_e: if (conv_done) st_next = tpa_pkg::tpa_idle_e;
         default:             st_next = tpa_pkg::tpa_idle_e;
      endcase
   end

   // Track-and-hold follows the serial clock's falling edge
   logic track_arm_reg;
   always_ff @(posedge serial_clock_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg        <= tpa_pkg::tpa_idle_e;
         cnt_reg       <= 5'h00;
         shift_reg     <= tpa_pkg::CTRL_RESET;
         word_reg      <= tpa_pkg::CTRL_RESET;
         track_arm_reg <= 1'b0;
         conv_s_reg    <= 1'b0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= (st_next != st_reg) ? 5'h00 : cnt_reg + 5'h01;
         if (st_reg == tpa_pkg::tpa_word_e) begin
            shift_reg <= {shift_reg[5:0], serial_data_in};
         end
         if (st_reg == tpa_pkg::tpa_word_e && st_next == tpa_pkg::tpa_acq_e) begin
            word_reg <= {shift_reg[5:0], serial_data_in};
         end
         // Track window: from fifth falling edge for three cycles
         if (fall_count_hit) track_arm_reg <= 1'b1;
         else if (acq_done)  track_arm_reg <= 1'b0;
         conv_s_reg <= (st_next == tpa_pkg::tpa_conv_e);
      end
   end

   always_ff @(negedge serial_clock_in or negedge rst_n) begin
      if (!rst_n) track_s_reg <= 1'b0;
      else        track_s_reg <= track_arm_reg;
   end

   // Word loaded pulse, one serial cycle
   logic load_d_reg;
   always_ff @(posedge serial_clock_in or negedge rst_n) begin
      if (!rst_n) load_d_reg <= 1'b0;
      else        load_d_reg <= (st_reg == tpa_pkg::tpa_word_e) &&
                                (st_next == tpa_pkg::tpa_acq_e);
   end
   assign load_pulse_s = load_d_reg;

   // ----------------------------------------------------------------
   // Crossing into mclk
   // ----------------------------------------------------------------
   logic       load_m;
   logic       track_m;
   logic       conv_m;
   logic       mode15_m;
   // Word is stable from load until the next load, several serial cycles later
   tpa_toggle_sync u_load (
      .src_clk   (serial_clock_in),
      .src_rst_n (rst_n),
      .src_pulse (load_pulse_s),
      .dst_clk   (mclk),
      .dst_rst_n (rst_n),
      .dst_pulse (load_m)
   );
   tpa_sync2 #(.W(3)) u_lvl (
      .clk   (mclk),
      .rst_n (rst_n),
      .d     ({track_s_reg, conv_s_reg, fifteen_clock_mode}),
      .q     ({track_m, conv_m, mode15_m})
   );

   // ----------------------------------------------------------------
   // Control word in mclk domain
   // ----------------------------------------------------------------
   logic [6:0] cw_reg;
   logic       temp_second_reg;
   logic       temp_second_next;
   logic       is_temp0;
   logic       is_temp1;
   logic       load_pend_reg;
   logic       apply_cw;
   // A load seen while tracking waits here instead of being lost
   assign apply_cw = (load_m || load_pend_reg) && !track_m;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cw_reg          <= tpa_pkg::CTRL_RESET;
         temp_second_reg <= 1'b0;
         load_pend_reg   <= 1'b0;
      end else begin
         load_pend_reg <= (load_m || load_pend_reg) && track_m;
         if (apply_cw) begin
            // Routing only changes outside acquisition
            cw_reg          <= word_reg;
            temp_second_reg <= temp_second_next;
         end
      end
   end

   logic [2:0] ch;
   logic [1:0] pd;
   logic       ser;
   assign ch  = cw_reg[tpa_pkg::POS_A2:tpa_pkg::POS_A0];
   assign pd  = {cw_reg[tpa_pkg::POS_PD1], cw_reg[tpa_pkg::POS_PD0]};
   assign ser = cw_reg[tpa_pkg::POS_SER];
   assign is_temp0 = (word_reg[tpa_pkg::POS_A2:tpa_pkg::POS_A0] == tpa_pkg::CH_TEMP0);
   assign is_temp1 = (word_reg[tpa_pkg::POS_A2:tpa_pkg::POS_A0] == tpa_pkg::CH_TEMP1);
   // Second diode reading uses the multiplied bias current
   assign temp_second_next = is_temp1 ? 1'b1 : (is_temp0 ? 1'b0 : temp_second_reg);

   // ----------------------------------------------------------------
   // Driver and reference routing
   // ----------------------------------------------------------------
   logic drv_need;
   logic keep_on;
   logic y_meas;
   logic x_meas;
   logic z_meas;
   logic drv_phase;
   logic ref_on;
   assign y_meas  = (ch == tpa_pkg::CH_XP);
   assign x_meas  = (ch == tpa_pkg::CH_YP);
   assign z_meas  = (ch == tpa_pkg::CH_Z1) || (ch == tpa_pkg::CH_Z2);
   assign keep_on = (pd == 2'h3) || mode15_m;
   // Single-ended: drivers only while tracking; differential: through conversion
   assign drv_phase = ser ? track_m
                          : (track_m || conv_m);
   assign drv_need  = keep_on || drv_phase;
   assign ref_on    = pd[1];

   logic [3:0] drv_next;
   assign drv_next[0] = drv_need && x_meas;            // X+
   assign drv_next[1] = drv_need && (x_meas || z_meas); // X-
   assign drv_next[2] = drv_need && (y_meas || z_meas); // Y+
   assign drv_next[3] = drv_need && y_meas;             // Y-

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         x_plus_drv              <= 1'b0;
         x_minus_drv             <= 1'b0;
         y_plus_drv              <= 1'b0;
         y_minus_drv             <= 1'b0;
         ref_enable              <= 1'b0;
         reference_output_switch <= 1'b0;
         track_active            <= 1'b0;
         conv_active             <= 1'b0;
      end else begin
         x_plus_drv              <= drv_next[0];
         x_minus_drv             <= drv_next[1];
         y_plus_drv              <= drv_next[2];
         y_minus_drv             <= drv_next[3];
         ref_enable              <= ref_on;
         reference_output_switch <= ref_on;
         track_active            <= track_m;
         conv_active             <= conv_m;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ref_plus_is_vref   <= 1'b1;
         ref_plus_is_yp     <= 1'b0;
         ref_plus_is_xp     <= 1'b0;
         ref_minus_is_gnd   <= 1'b1;
         ref_minus_is_ym    <= 1'b0;
         ref_minus_is_xm    <= 1'b0;
         adc_in_xp          <= 1'b0;
         adc_in_yp          <= 1'b0;
         adc_in_ym          <= 1'b0;
         adc_in_aux         <= 1'b0;
         adc_in_vbat        <= 1'b0;
         adc_in_temp        <= 1'b0;
         temp_bias_multiple <= 1'b0;
         res_8bit           <= 1'b0;
         reference_select   <= 1'b0;
      end else begin
         ref_plus_is_vref   <= ser;
         ref_minus_is_gnd   <= ser;
         ref_plus_is_yp     <= !ser && (y_meas || z_meas);
         ref_minus_is_ym    <= !ser && y_meas;
         ref_plus_is_xp     <= !ser && x_meas;
         ref_minus_is_xm    <= !ser && (x_meas || z_meas);
         adc_in_xp          <= y_meas || (ch == tpa_pkg::CH_Z1);
         adc_in_yp          <= x_meas;
         adc_in_ym          <= (ch == tpa_pkg::CH_Z2);
         adc_in_aux         <= ser && (ch == tpa_pkg::CH_AUX);
         adc_in_vbat        <= ser && (ch == tpa_pkg::CH_VBAT);
         adc_in_temp        <= ser && ((ch == tpa_pkg::CH_TEMP0) ||
                                       (ch == tpa_pkg::CH_TEMP1));
         temp_bias_multiple <= temp_second_reg && ser &&
                               (ch == tpa_pkg::CH_TEMP1);
         res_8bit           <= cw_reg[tpa_pkg::POS_RES];
         reference_select   <= ser;
      end
   end
endmodule : tpa_ctrl

// *** rtl/tpa_pkg.sv ***
// Purpose: Shared constants for the touch panel acquire/reference control
// Assumes: Control word is start, A2..A0, resolution, reference_select, PD1, PD0
// Notes:   Bit positions count from the last bit received, PD0 at zero
package tpa_pkg;
   localparam int          CTRL_BITS       = 7;
   localparam int          POS_A2          = 6;
   localparam int          POS_A0          = 4;
   localparam int          POS_RES         = 3;
   localparam int          POS_SER         = 2;
   localparam int          POS_PD1         = 1;
   localparam int          POS_PD0         = 0;
   localparam int          TRACK_FALL      = 5;
   localparam int          ACQ_CYCLES      = 3;
   localparam int          CONV_BITS_12    = 12;
   localparam int          CONV_BITS_8     = 8;
   localparam logic [2:0]  CH_TEMP0        = 3'h0;
   localparam logic [2:0]  CH_XP           = 3'h1;
   localparam logic [2:0]  CH_VBAT         = 3'h2;
   localparam logic [2:0]  CH_Z1           = 3'h3;
   localparam logic [2:0]  CH_Z2           = 3'h4;
   localparam logic [2:0]  CH_YP           = 3'h5;
   localparam logic [2:0]  CH_AUX          = 3'h6;
   localparam logic [2:0]  CH_TEMP1        = 3'h7;
   localparam logic [1:0]  PD_RESET        = 2'h0;
   localparam logic [6:0]  CTRL_RESET      = 7'h00;
   typedef enum logic [1:0] {
      tpa_idle_e, tpa_word_e, tpa_acq_e, tpa_conv_e
   } tpa_state_e;
endpackage : tpa_pkg

// *** rtl/tpa_sync2.sv ***
// Purpose: Two-flop level synchroniser
// Assumes: Input is asynchronous to clk
// Notes:   First flop is read only by the second
`timescale 1ns/1ps
module tpa_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   initial begin
      if (W < 1) $error("W must be positive");
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : tpa_sync2

// *** rtl/tpa_toggle_sync.sv ***
// Purpose: Moves a one-cycle event between clock domains by a toggle
// Assumes: Events are spaced by at least three destination cycles
// Notes:   Output is a one-cycle pulse in the destination domain
`timescale 1ns/1ps
module tpa_toggle_sync (
   input  wire logic src_clk,
   input  wire logic src_rst_n,
   input  wire logic src_pulse,
   input  wire logic dst_clk,
   input  wire logic dst_rst_n,
   output logic      dst_pulse
);
   logic tog_reg;
   logic tog_sync;
   logic tog_last_reg;
   always_ff @(posedge src_clk or negedge src_rst_n) begin
      if (!src_rst_n) tog_reg <= 1'b0;
      else            tog_reg <= tog_reg ^ src_pulse;
   end
   tpa_sync2 #(.W(1)) u_sync (
      .clk   (dst_clk),
      .rst_n (dst_rst_n),
      .d     (tog_reg),
      .q     (tog_sync)
   );
   always_ff @(posedge dst_clk or negedge dst_rst_n) begin
      if (!dst_rst_n) begin
         tog_last_reg <= 1'b0;
         dst_pulse    <= 1'b0;
      end else begin
         tog_last_reg <= tog_sync;
         dst_pulse    <= tog_sync ^ tog_last_reg;
      end
   end
endmodule : tpa_toggle_sync

// *** verification/tpa_ctrl_props.sv ***
// Purpose: Port checks for tpa_ctrl
// Assumes: All checks on mclk, off in reset
// Notes:   Bound to every tpa_ctrl below
`timescale 1ns/1ps
module tpa_ctrl_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic track_active,
   input wire logic conv_active,
   input wire logic y_plus_drv,
   input wire logic y_minus_drv,
   input wire logic ref_enable,
   input wire logic reference_output_switch,
   input wire logic ref_plus_is_vref,
   input wire logic ref_plus_is_yp,
   input wire logic ref_plus_is_xp,
   input wire logic ref_minus_is_gnd,
   input wire logic ref_minus_is_ym,
   input wire logic adc_in_xp,
   input wire logic adc_in_temp,
   input wire logic temp_bias_multiple,
   input wire logic reference_select
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_track_min_len: assert property ($rose(track_active) |=> track_active [*2])
      else $error("tracking too short");
   a_track_to_conv: assert property ($fell(track_active) |-> ##[0:2] conv_active)
      else $error("no conversion after tracking");
   a_switch_follows: assert property (reference_output_switch == ref_enable)
      else $error("reference switch differs from enable");
   a_se_ref_taps: assert property (reference_select [*4] |-> ref_plus_is_vref && ref_minus_is_gnd)
      else $error("single-ended taps wrong");
   a_taps_exclusive: assert property ((ref_plus_is_yp || ref_plus_is_xp) |->
      !ref_plus_is_vref && !ref_minus_is_gnd)
      else $error("plate and fixed taps together");
   a_diff_drivers_on: assert property (conv_active && $past(conv_active) && ref_plus_is_yp
      && ref_minus_is_ym |-> y_plus_drv && y_minus_drv)
      else $error("drivers off in ratiometric conversion");
   a_route_hold: assert property (track_active && $past(track_active) |->
      $stable({adc_in_xp, adc_in_temp, ref_plus_is_yp, ref_minus_is_ym, y_plus_drv}))
      else $error("routing changed while tracking");
   a_temp_bias_chan: assert property (temp_bias_multiple |-> adc_in_temp)
      else $error("bias multiple without diode input");
endmodule : tpa_ctrl_props

bind tpa_ctrl tpa_ctrl_props PROPS (.mclk, .rst_n, .track_active, .conv_active, .y_plus_drv,
   .y_minus_drv, .ref_enable, .reference_output_switch, .ref_plus_is_vref, .ref_plus_is_yp,
   .ref_plus_is_xp, .ref_minus_is_gnd, .ref_minus_is_ym, .adc_in_xp, .adc_in_temp,
   .temp_bias_multiple, .reference_select);

// *** verification/tpa_ctrl_tb.sv ***
// Purpose: Self-checking bench for tpa_ctrl
// Assumes: Host model drives the serial side
// Notes:   Fixed-seed xorshift words plus corner words
`timescale 1ns/1ps
module tpa_ctrl_tb;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        fifteen_clock_mode = 1'b0;
   logic        serial_clock_in, serial_data_in, track_active, conv_active;
   logic        x_plus_drv, x_minus_drv, y_plus_drv, y_minus_drv, ref_enable;
   logic        reference_output_switch, ref_plus_is_vref, ref_plus_is_yp, ref_plus_is_xp;
   logic        ref_minus_is_gnd, ref_minus_is_ym, ref_minus_is_xm, adc_in_xp, adc_in_yp;
   logic        adc_in_ym, adc_in_aux, adc_in_vbat, adc_in_temp, temp_bias_multiple;
   logic        res_8bit, reference_select;
   logic [22:0] outs;
   logic [31:0] rnd = 32'h86C270A4;
   logic [6:0]  w;
   logic [6:0]  corner [6] = '{7'h13, 7'h14, 7'h10, 7'h06, 7'h7E, 7'h51};
   int          err_total = 0;
   int          compares = 0;
   assign outs = {track_active, conv_active, x_plus_drv, x_minus_drv, y_plus_drv, y_minus_drv,
      ref_enable, reference_output_switch, ref_plus_is_vref, ref_plus_is_yp, ref_plus_is_xp,
      ref_minus_is_gnd, ref_minus_is_ym, ref_minus_is_xm, adc_in_xp, adc_in_yp, adc_in_ym,
      adc_in_aux, adc_in_vbat, adc_in_temp, temp_bias_multiple, res_8bit, reference_select};
   always #20 mclk = ~mclk;
   tpa_ctrl DUT (.mclk, .rst_n, .serial_clock_in, .serial_data_in, .fifteen_clock_mode,
      .track_active, .conv_active, .x_plus_drv, .x_minus_drv, .y_plus_drv, .y_minus_drv,
      .ref_enable, .reference_output_switch, .ref_plus_is_vref, .ref_plus_is_yp,
      .ref_plus_is_xp, .ref_minus_is_gnd, .ref_minus_is_ym, .ref_minus_is_xm, .adc_in_xp,
      .adc_in_yp, .adc_in_ym, .adc_in_aux, .adc_in_vbat, .adc_in_temp, .temp_bias_multiple,
      .res_8bit, .reference_select);
   tpa_host_model HOST (.serial_clock_in, .serial_data_in);
   // ------------------------------------------------------------
   // Expectations and checks
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   // Reference taps above converter inputs
   function automatic logic [11:0] exp_route(input logic [2:0] ch, input logic ser);
      logic [5:0] a;
      logic [5:0] r;
      case (ch)
         3'h1: {a, r} = {6'h20, 6'h12};
         3'h3: {a, r} = {6'h20, 6'h11};
         3'h4: {a, r} = {6'h08, 6'h11};
         3'h5: {a, r} = {6'h10, 6'h09};
         3'h6: {a, r} = {6'h04, 6'h24};
         3'h2: {a, r} = {6'h02, 6'h24};
         default: {a, r} = {6'h01, 6'h24};
      endcase
      return {(ser ? 6'h24 : r), a};
   endfunction : exp_route
   task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic wait_bit(input int b, input int lim);
      int n;
      n = 0;
      while (outs[b] !== 1'b1 && n < lim) begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_bit
   task automatic frame(input logic [6:0] c, input int lead, input int stall);
      fork
         HOST.send(c, lead, stall);
         begin
            @(HOST.fifth_fall);
            chk(outs[22], 1'b0, "early track");
            wait_bit(22, 8);
            chk(outs[22], 1'b1, "late track");
            if (c[6:4] == 3'h1 && !c[2]) begin
               wait_bit(21, 30);
               repeat (6) @(negedge mclk);
               chk(outs[18:17], 2'h3, "drivers off in conversion");
            end
         end
      join
      repeat (12) @(negedge mclk);
      chk(outs[14:3], exp_route(c[6:4], c[2]), "routing");
      chk(outs[16:15], {c[1], c[1]}, "reference enable");
      chk(outs[1:0], c[3:2], "mode bits");
      if (c[6:4] == 3'h0 || c[6:4] == 3'h7) chk(outs[2], c[6], "diode bias");
      if (c[6:4] == 3'h1)
         chk(outs[20:17], (c[1:0] == 2'h3 || fifteen_clock_mode) ? 4'h3 : 4'h0, "drivers");
   endtask : frame
   task automatic print_verdict;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk(outs, 23'h004800, "reset values");
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         fifteen_clock_mode <= (i == 2);
         frame(corner[i], i, (i == 1) ? 400 : 0);
      end
      for (int i = 0; i < 24; i++) begin
         rnd = xs(rnd);
         w = rnd[6:0];
         if (w[6:4] inside {3'h0, 3'h2, 3'h6, 3'h7}) w[2] = 1'b1;
         @(posedge mclk);
         fifteen_clock_mode <= rnd[9] & rnd[10];
         frame(w, int'(rnd[13:11]), 0);
      end
      print_verdict();
   end
endmodule : tpa_ctrl_tb

// *** verification/tpa_host_model.sv ***
// Purpose: Host end of the serial control link
// Assumes: 48 ns serial clock, stopped low between frames
// Notes:   Data changes after each falling edge
`timescale 1ns/1ps
module tpa_host_model (
   output logic serial_clock_in,
   output logic serial_data_in
);
   event fifth_fall;
   initial begin
      serial_clock_in = 1'b0;
      serial_data_in = 1'b1;
   end
   task automatic cyc(input logic d);
      serial_data_in = d;
      #24;
      serial_clock_in = 1'b1;
      #24;
      serial_clock_in = 1'b0;
   endtask : cyc
   task automatic send(input logic [6:0] w, input int lead, input int stall);
      #7;
      repeat (lead) cyc(1'b0);
      cyc(1'b1);
      for (int k = 6; k >= 0; k--) begin
         cyc(w[k]);
         if (k == 2) -> fifth_fall;
      end
      #(stall);
      repeat (tpa_pkg::ACQ_CYCLES + (w[3] ? tpa_pkg::CONV_BITS_8 : tpa_pkg::CONV_BITS_12) + 2)
         cyc(1'b0);
      serial_data_in = ~w[0];
   endtask : send
endmodule : tpa_host_model
